// [bridge_defs.vh]
// constants for the serial master bridge
`ifndef BRIDGE_DEFS_VH
`define BRIDGE_DEFS_VH
`define CMD_BUF_WRITE 16'h0a01
`define CMD_BUF_READ 16'h0a02
`define CMD_START_XFER 16'h0a03
`define PEC_SEED 15'h0010
`define PEC_POLY 15'h4599
`define CNT_CMD_END 8'd16
`define CNT_HDR_LAST 8'd31
`define CNT_DATA_BEG 8'd32
`define CNT_DATA_END 8'd80
`define CNT_PEC_LAST 8'd95
`define CNT_CRC_LAST 8'd94
`define CNT_RD_BASE 8'd79
`define SLOT_LAST_CYC 5'd23
`define SLOT_LAST 2'd2
`define I2C_PRE_START 4'b0110
`define I2C_PRE_STOP 4'b0001
`define I2C_PRE_BLANK 4'b0000
`define I2C_PRE_NOTX 4'b0111
`define I2C_POST_ACK 4'b0000
`define I2C_POST_NACK 4'b1000
`define I2C_POST_NACK_STOP 4'b1001
`define I2C_RB_SLV_ACK 4'b0111
`define I2C_RB_SLV_NACK 4'b1111
`define I2C_RB_ACK_STOP 4'b0001
`define I2C_RB_NACK_STOP 4'b1001
`define SPI_PRE_SEL_LOW 4'b1000
`define SPI_PRE_SEL_HIGH 4'b1001
`define SPI_PRE_NOTX 4'b1111
`define SPI_POST_RAISE 4'b1001
`define SPI_RB_PRE 4'b0111
`define SPI_RB_POST 4'b1111
`define CLK_MHZ 100
`define WDT_TIME_MS 2000
`define WDT_CYCLES 28'd200000000
`endif

// [sync2.v]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync2 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q_ff
);
  reg [W-1:0] meta_ff;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule

// [pec15_serial.v]
// bit-serial 15-bit packet error code generator
`timescale 1ns/10ps
`include "bridge_defs.vh"
module pec15_serial (
  input wire clk_sys,
  input wire sys_rst,
  input wire clear,
  input wire shift_en,
  input wire data_bit,
  output reg [14:0] crc_ff
);
  wire fb = data_bit ^ crc_ff[14];
  always @(posedge clk_sys) begin
    if (sys_rst || clear) begin
      crc_ff <= `PEC_SEED;
    end else if (shift_en) begin
      crc_ff <= {crc_ff[13:0], 1'b0} ^ (fb ? `PEC_POLY : 15'h0000);
    end
  end
endmodule

// [gpio_i2c_spi_master_bridge.v]
// host spi slave with buffered i2c/spi master on three open-drain pins
// Operation
// - write command takes six bytes plus code
// - bad write code fills buffer with ones
// - start command exchanges three bytes with slave
// - pins: four sda, five scl; three select
// - read command returns six bytes plus code
// - i2c pre-byte readback codes
// - i2c post-byte readback codes
// - spi readback codes fixed 0111 and 1111
// - data readback holds sent or captured byte
// - pins hold between commands; watchdog releases
// - i2c stop then lines high, slot skipped
// - i2c no-transmit releases lines, slot skipped
// - spi select-high or no-transmit releases, skips
// - master timing from host clocks, scl two
// - host port mode 3, max 1 Mbps
// - host port active when strap tied low
// - top pre-byte bit selects protocol
// - i2c write codes obeyed
// - spi write codes obeyed
// - buffer holds three pre/data/post slots
`timescale 1ns/10ps
`include "bridge_defs.vh"
module gpio_i2c_spi_master_bridge #(
  parameter [27:0] WDT_LIMIT = `WDT_CYCLES
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire isolation_mode_strap,
  input wire host_chip_select_n,
  input wire host_sck,
  input wire host_sdi,
  output reg host_sdo_out_ff,
  output reg host_sdo_oe_n_ff,
  input wire general_pin_three_in,
  output reg general_pin_three_out_ff,
  output reg general_pin_three_oe_n_ff,
  input wire general_pin_four_in,
  output reg general_pin_four_out_ff,
  output reg general_pin_four_oe_n_ff,
  input wire general_pin_five_in,
  output reg general_pin_five_out_ff,
  output reg general_pin_five_oe_n_ff,
  output reg pec_error_ff,
  output reg transfer_busy_ff,
  output reg watchdog_fired_ff
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CMD = 5'b00010;
  localparam [4:0] ST_WRITE = 5'b00100;
  localparam [4:0] ST_READ = 5'b01000;
  localparam [4:0] ST_XFER = 5'b10000;

  function [15:0] slot_word;
    input [47:0] b;
    input [1:0] s;
    begin
      case (s)
        2'd0: slot_word = b[47:32];
        2'd1: slot_word = b[31:16];
        default: slot_word = b[15:0];
      endcase
    end
  endfunction

  function [47:0] slot_put;
    input [47:0] b;
    input [1:0] s;
    input [15:0] w;
    begin
      case (s)
        2'd0: slot_put = {w, b[31:0]};
        2'd1: slot_put = {b[47:32], w, b[15:0]};
        default: slot_put = {b[47:16], w};
      endcase
    end
  endfunction

  wire [5:0] sync_q;
  sync2 #(.W(6), .RST_VAL(6'h3f)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({isolation_mode_strap, host_chip_select_n, host_sck, host_sdi,
        general_pin_four_in, general_pin_three_in}),
    .q_ff(sync_q)
  );
  wire strap_q = sync_q[5];
  wire cs_q = sync_q[4];
  wire sck_q = sync_q[3];
  wire sdi_q = sync_q[2];
  wire data_line_q = sync_q[1];

  reg cs_prev_ff;
  reg sck_prev_ff;
  reg [4:0] st_ff;
  reg [7:0] bit_cnt_ff;
  reg [15:0] cmd_sr_ff;
  reg [15:0] pec_sr_ff;
  reg wr_ok_ff;
  reg [47:0] buffer_a_ff;
  reg [4:0] cyc_ff;
  reg [1:0] slot_ff;
  reg xfer_done_ff;
  reg skip_ff;
  reg [8:0] cap_ff;
  reg [3:0] pre_rb_ff;
  reg [27:0] wdt_cnt_ff;

  // mode 3: sample on rising, shift out on falling
  wire sck_rise = sck_q & ~sck_prev_ff;
  wire sck_fall = ~sck_q & sck_prev_ff;
  wire cs_fall = cs_prev_ff & ~cs_q;
  wire cs_rise = ~cs_prev_ff & cs_q;
  wire frame_on = ~cs_q;

  wire [14:0] rx_crc;
  wire [14:0] tx_crc;
  wire [15:0] pec_next = {pec_sr_ff[14:0], sdi_q};
  wire hdr_done = sck_rise && frame_on && (st_ff == ST_CMD) && (bit_cnt_ff == `CNT_HDR_LAST);
  wire hdr_ok = (pec_next == {rx_crc, 1'b0});
  wire in_data = (bit_cnt_ff >= `CNT_DATA_BEG) && (bit_cnt_ff < `CNT_DATA_END);
  wire [7:0] rd_idx = `CNT_RD_BASE - bit_cnt_ff;
  wire [7:0] crc_idx = `CNT_CRC_LAST - bit_cnt_ff;
  wire rd_bit = buffer_a_ff[rd_idx[5:0]];
  wire rx_en = sck_rise && frame_on
    && (((st_ff == ST_CMD) && (bit_cnt_ff < `CNT_CMD_END)) || ((st_ff == ST_WRITE) && in_data));
  wire tx_en = sck_fall && frame_on && (st_ff == ST_READ) && in_data;

  pec15_serial u_rx_pec (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(cs_fall | hdr_done),
    .shift_en(rx_en),
    .data_bit(sdi_q),
    .crc_ff(rx_crc)
  );

  pec15_serial u_tx_pec (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(cs_fall),
    .shift_en(tx_en),
    .data_bit(rd_bit),
    .crc_ff(tx_crc)
  );

  // current slot fields
  wire [15:0] cur = slot_word(buffer_a_ff, slot_ff);
  wire [3:0] pre = cur[15:12];
  wire [7:0] dat = cur[11:4];
  wire [3:0] post = cur[3:0];
  // protocol select from top bit (i2c codes carry a zero there)
  wire is_i2c = ~pre[3];
  wire eng_step = sck_rise && frame_on && (st_ff == ST_XFER) && !xfer_done_ff;
  wire [4:0] k_odd = (cyc_ff - 5'd3) >> 1;
  wire [4:0] k_even = (cyc_ff - 5'd4) >> 1;
  wire [4:0] last_bit = is_i2c ? 5'd8 : 5'd7;
  wire odd_slot = cyc_ff[0] && (cyc_ff >= 5'd3) && (cyc_ff <= 5'd21);
  wire even_slot = !cyc_ff[0] && (cyc_ff >= 5'd4) && (cyc_ff <= 5'd20);
  wire ack_high = cap_ff[0];

  // readback post field
  reg [3:0] post_rb;
  always @* begin
    post_rb = `SPI_RB_POST;
    if (is_i2c && !skip_ff) begin
      if (post == `I2C_POST_ACK) begin
        post_rb = `I2C_POST_ACK;
      end else if (post == `I2C_POST_NACK_STOP) begin
        post_rb = ack_high ? `I2C_RB_NACK_STOP : `I2C_RB_ACK_STOP;
      end else begin
        post_rb = ack_high ? `I2C_RB_SLV_NACK : `I2C_RB_SLV_ACK;
      end
    end
  end

  // captured byte replaces the sent one unless the slot is skipped
  wire [7:0] rb_data = skip_ff ? dat : (is_i2c ? cap_ff[8:1] : cap_ff[7:0]);
  wire [15:0] rb_word = {(is_i2c ? pre_rb_ff : `SPI_RB_PRE), rb_data, post_rb};

  // host frame decode
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cs_prev_ff <= 1'b1;
      sck_prev_ff <= 1'b1;
      st_ff <= ST_IDLE;
      bit_cnt_ff <= 8'h00;
      cmd_sr_ff <= 16'h0000;
      pec_sr_ff <= 16'h0000;
      wr_ok_ff <= 1'b0;
      pec_error_ff <= 1'b0;
      host_sdo_out_ff <= 1'b0;
      host_sdo_oe_n_ff <= 1'b1;
    end else begin
      cs_prev_ff <= cs_q;
      sck_prev_ff <= sck_q;
      if (cs_fall) begin
        // host port serves frames only with strap low
        st_ff <= strap_q ? ST_IDLE : ST_CMD;
        bit_cnt_ff <= 8'h00;
        wr_ok_ff <= 1'b0;
      end else if (!frame_on) begin
        st_ff <= ST_IDLE;
        host_sdo_oe_n_ff <= 1'b1;
        // error flag on a bad write code
        if (cs_rise && (st_ff == ST_WRITE)) begin
          pec_error_ff <= !wr_ok_ff;
        end
      end else if (sck_rise && (st_ff != ST_IDLE)) begin
        if (bit_cnt_ff != 8'hff) begin
          bit_cnt_ff <= bit_cnt_ff + 8'h01;
        end
        if (bit_cnt_ff < `CNT_CMD_END) begin
          cmd_sr_ff <= {cmd_sr_ff[14:0], sdi_q};
        end else begin
          pec_sr_ff <= pec_next;
        end
        if (hdr_done) begin
          pec_error_ff <= !hdr_ok;
          if (!hdr_ok) begin
            st_ff <= ST_IDLE;
          end else if (cmd_sr_ff == `CMD_BUF_WRITE) begin
            st_ff <= ST_WRITE;
          end else if (cmd_sr_ff == `CMD_BUF_READ) begin
            st_ff <= ST_READ;
          end else if (cmd_sr_ff == `CMD_START_XFER) begin
            st_ff <= ST_XFER;
          end else begin
            st_ff <= ST_IDLE;
          end
        end
        // six bytes then the code, nothing more
        if (st_ff == ST_WRITE) begin
          if (bit_cnt_ff == `CNT_PEC_LAST) begin
            wr_ok_ff <= hdr_ok;
          end else if (bit_cnt_ff > `CNT_PEC_LAST) begin
            wr_ok_ff <= 1'b0;
          end
        end
      end else if (sck_fall && (st_ff == ST_READ)) begin
        // six bytes then the code on the open-drain output
        if (in_data) begin
          host_sdo_oe_n_ff <= rd_bit;
        end else if (bit_cnt_ff < `CNT_PEC_LAST) begin
          host_sdo_oe_n_ff <= tx_crc[crc_idx[3:0]];
        end else if (bit_cnt_ff == `CNT_PEC_LAST) begin
          host_sdo_oe_n_ff <= 1'b0;
        end else begin
          host_sdo_oe_n_ff <= 1'b1;
        end
      end
    end
  end

  // buffer, transfer engine, pins and watchdog
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      buffer_a_ff <= 48'hffffffffffff;
      cyc_ff <= 5'd0;
      slot_ff <= 2'd0;
      xfer_done_ff <= 1'b1;
      skip_ff <= 1'b0;
      cap_ff <= 9'h000;
      pre_rb_ff <= `I2C_PRE_NOTX;
      wdt_cnt_ff <= 28'h0000000;
      watchdog_fired_ff <= 1'b0;
      transfer_busy_ff <= 1'b0;
      general_pin_three_out_ff <= 1'b0;
      general_pin_four_out_ff <= 1'b0;
      general_pin_five_out_ff <= 1'b0;
      general_pin_three_oe_n_ff <= 1'b1;
      general_pin_four_oe_n_ff <= 1'b1;
      general_pin_five_oe_n_ff <= 1'b1;
    end else begin
      transfer_busy_ff <= (st_ff == ST_XFER) && frame_on && !xfer_done_ff;
      if (cs_rise && (st_ff == ST_WRITE) && !wr_ok_ff) begin
        buffer_a_ff <= 48'hffffffffffff;
      end else if (sck_rise && frame_on && (st_ff == ST_WRITE) && in_data) begin
        buffer_a_ff <= {buffer_a_ff[46:0], sdi_q};
      end
      // watchdog restarts on every accepted command
      if (hdr_done && hdr_ok) begin
        wdt_cnt_ff <= 28'h0000000;
        watchdog_fired_ff <= 1'b0;
        cyc_ff <= 5'd0;
        slot_ff <= 2'd0;
        skip_ff <= 1'b0;
        xfer_done_ff <= (cmd_sr_ff != `CMD_START_XFER);
      end else if (wdt_cnt_ff == WDT_LIMIT) begin
        if (!watchdog_fired_ff) begin
          general_pin_three_oe_n_ff <= 1'b1;
          general_pin_four_oe_n_ff <= 1'b1;
          general_pin_five_oe_n_ff <= 1'b1;
        end
        watchdog_fired_ff <= 1'b1;
      end else begin
        wdt_cnt_ff <= wdt_cnt_ff + 28'h0000001;
      end
      // one engine step per host clock, 24 per slot
      // scl low and high each one host clock
      if (eng_step) begin
        if (cyc_ff == `SLOT_LAST_CYC) begin
          cyc_ff <= 5'd0;
          skip_ff <= 1'b0;
          if (slot_ff == `SLOT_LAST) begin
            xfer_done_ff <= 1'b1;
          end else begin
            slot_ff <= slot_ff + 2'd1;
          end
          // slot result replaces the buffered slot
          buffer_a_ff <= slot_put(buffer_a_ff, slot_ff, rb_word);
        end else begin
          cyc_ff <= cyc_ff + 5'd1;
        end
        if (cyc_ff == 5'd0) begin
          if (is_i2c) begin
            case (pre)
              `I2C_PRE_START: begin
                general_pin_four_oe_n_ff <= 1'b1;
                general_pin_five_oe_n_ff <= 1'b1;
                pre_rb_ff <= `I2C_PRE_START;
              end
              `I2C_PRE_STOP: begin
                general_pin_four_oe_n_ff <= 1'b0;
                pre_rb_ff <= `I2C_PRE_STOP;
              end
              `I2C_PRE_NOTX: begin
                general_pin_four_oe_n_ff <= 1'b1;
                general_pin_five_oe_n_ff <= 1'b1;
                skip_ff <= 1'b1;
                pre_rb_ff <= `I2C_PRE_NOTX;
              end
              default: begin
                pre_rb_ff <= data_line_q ? `I2C_PRE_NOTX : `I2C_PRE_BLANK;
              end
            endcase
          end else if (pre == `SPI_PRE_SEL_LOW) begin
            general_pin_three_oe_n_ff <= 1'b0;
          end else begin
            // release select, clock and data, skip
            general_pin_three_oe_n_ff <= 1'b1;
            general_pin_four_oe_n_ff <= 1'b1;
            general_pin_five_oe_n_ff <= 1'b1;
            skip_ff <= 1'b1;
          end
        end else if (is_i2c && (cyc_ff == 5'd1) && !skip_ff) begin
          if (pre == `I2C_PRE_START) begin
            general_pin_four_oe_n_ff <= 1'b0;
          end else if (pre == `I2C_PRE_STOP) begin
            general_pin_five_oe_n_ff <= 1'b1;
          end
        end else if (is_i2c && (cyc_ff == 5'd2) && !skip_ff) begin
          if (pre == `I2C_PRE_START) begin
            general_pin_five_oe_n_ff <= 1'b0;
          end else if (pre == `I2C_PRE_STOP) begin
            // stop done, lines high, rest ignored
            general_pin_four_oe_n_ff <= 1'b1;
            skip_ff <= 1'b1;
          end
        end else if (odd_slot && !skip_ff) begin
          if ((k_odd >= 5'd1) && (k_odd <= last_bit + 5'd1)) begin
            cap_ff <= {cap_ff[7:0], data_line_q};
          end
          // pin five clocks, pin four carries data
          if (k_odd <= last_bit) begin
            general_pin_five_oe_n_ff <= 1'b0;
            if (k_odd < 5'd8) begin
              general_pin_four_oe_n_ff <= dat[3'd7 - k_odd[2:0]];
            end else begin
              general_pin_four_oe_n_ff <= (post != `I2C_POST_ACK);
            end
          end else if (is_i2c && (post == `I2C_POST_NACK_STOP)) begin
            general_pin_five_oe_n_ff <= 1'b0;
            general_pin_four_oe_n_ff <= 1'b0;
          end
        end else if (even_slot && !skip_ff) begin
          if (k_even <= last_bit) begin
            general_pin_five_oe_n_ff <= 1'b1;
          end
        end else if ((cyc_ff == 5'd22) && !skip_ff) begin
          if (is_i2c && (post == `I2C_POST_NACK_STOP)) begin
            general_pin_five_oe_n_ff <= 1'b1;
          end
        end else if ((cyc_ff == `SLOT_LAST_CYC) && !skip_ff) begin
          if (is_i2c && (post == `I2C_POST_NACK_STOP)) begin
            general_pin_four_oe_n_ff <= 1'b1;
          end else if (!is_i2c && (post == `SPI_POST_RAISE)) begin
            general_pin_three_oe_n_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// [bridge_properties.sv]
// concurrent checks on the bridge ports
`timescale 1ns/10ps
module bridge_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic isolation_mode_strap,
  input wire logic host_chip_select_n,
  input wire logic host_sck,
  input wire logic host_sdo_out_ff,
  input wire logic host_sdo_oe_n_ff,
  input wire logic general_pin_three_out_ff,
  input wire logic general_pin_three_oe_n_ff,
  input wire logic general_pin_four_out_ff,
  input wire logic general_pin_four_oe_n_ff,
  input wire logic general_pin_five_out_ff,
  input wire logic general_pin_five_oe_n_ff,
  input wire logic transfer_busy_ff,
  input wire logic watchdog_fired_ff
);
  wire [2:0] pins_oe_n = {general_pin_three_oe_n_ff, general_pin_four_oe_n_ff,
    general_pin_five_oe_n_ff};
  wire [3:0] outs = {host_sdo_out_ff, general_pin_three_out_ff, general_pin_four_out_ff,
    general_pin_five_out_ff};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence sck_quiet;
    $stable(host_sck) [*6];
  endsequence
  rst_idle_a: assert property ($fell(sys_rst) |-> &pins_oe_n && host_sdo_oe_n_ff
    && !transfer_busy_ff && !watchdog_fired_ff) else $error("outputs not idle after reset");
  out_low_a: assert property (outs == 4'h0)
    else $error("open-drain output value not low");
  sdo_rel_a: assert property (host_chip_select_n [*5] |-> host_sdo_oe_n_ff)
    else $error("host data out driven outside a frame");
  sdo_hold_a: assert property ((host_sck && !host_chip_select_n) [*6]
    |=> $stable(host_sdo_oe_n_ff)) else $error("host data out changed while clock high");
  strap_off_a: assert property (isolation_mode_strap [*8] |-> host_sdo_oe_n_ff)
    else $error("host port answered with strap high");
  busy_cs_a: assert property ($rose(transfer_busy_ff) |-> !host_chip_select_n)
    else $error("transfer started outside a frame");
  wdt_rel_a: assert property ($rose(watchdog_fired_ff) |-> ##[0:2] &pins_oe_n)
    else $error("watchdog did not release the pins");
  pins_quiet_a: assert property (sck_quiet ##1 $changed(pins_oe_n)
    |-> ##[0:1] watchdog_fired_ff) else $error("pin moved without a host clock edge");
endmodule

bind gpio_i2c_spi_master_bridge bridge_properties i_bridge_properties (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .isolation_mode_strap(isolation_mode_strap),
  .host_chip_select_n(host_chip_select_n), .host_sck(host_sck),
  .host_sdo_out_ff(host_sdo_out_ff), .host_sdo_oe_n_ff(host_sdo_oe_n_ff),
  .general_pin_three_out_ff(general_pin_three_out_ff),
  .general_pin_three_oe_n_ff(general_pin_three_oe_n_ff),
  .general_pin_four_out_ff(general_pin_four_out_ff),
  .general_pin_four_oe_n_ff(general_pin_four_oe_n_ff),
  .general_pin_five_out_ff(general_pin_five_out_ff),
  .general_pin_five_oe_n_ff(general_pin_five_oe_n_ff),
  .transfer_busy_ff(transfer_busy_ff), .watchdog_fired_ff(watchdog_fired_ff));

// [bridge_slave_model.sv]
// behavioural downstream slave on the three general pins
`timescale 1ns/10ps
module bridge_slave_model (
  input wire logic sel,
  input wire logic sda,
  input wire logic scl,
  input wire logic nack_en,
  input wire logic [23:0] reply,
  output logic pull_low
);
  logic [23:0] sh = '1;
  int nb = 0;
  initial pull_low = 0;
  // a start condition restarts the bit count
  always @(negedge sda) if (scl === 1'b1) nb = 0;
  always @(posedge scl) if (sel === 1'b1) nb++;
  always @(negedge sel) sh = reply;
  // spi shifts on falling clock; i2c acks the ninth clock
  always @(negedge scl) begin
    if (sel === 1'b0) begin
      pull_low = ~sh[23];
      sh = {sh[22:0], 1'b1};
    end else begin
      pull_low = nb == 8 && !nack_en;
      if (nb == 9) nb = 0;
    end
  end
endmodule

// [tb_gpio_i2c_spi_master_bridge.sv]
// self-checking bench for the serial master bridge
`timescale 1ns/10ps
`include "bridge_defs.vh"
module tb_gpio_i2c_spi_master_bridge;
  logic clk_sys = 0, sys_rst = 1, strap = 0, cs_n = 1, sck = 1, sdi = 1, nack = 0;
  logic [23:0] reply = 0;
  wire slv_pull, p3o, p3e, p4o, p4e, p5o, p5e, sdo_o, sdo_e, pec_err, busy, wdt;
  wire pin3 = p3e | p3o;
  wire pin4 = (p4e | p4o) & ~slv_pull;
  wire pin5 = p5e | p5o;
  int error_cnt = 0, n_compared = 0, cyc = 0, m_n = 0, seed;
  logic [63:0] exp_q[$];
  logic [95:0] m_di, m_do;

  gpio_i2c_spi_master_bridge #(.WDT_LIMIT(28'd2000)) i_gpio_i2c_spi_master_bridge (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .isolation_mode_strap(strap),
    .host_chip_select_n(cs_n), .host_sck(sck), .host_sdi(sdi),
    .host_sdo_out_ff(sdo_o), .host_sdo_oe_n_ff(sdo_e),
    .general_pin_three_in(pin3), .general_pin_three_out_ff(p3o),
    .general_pin_three_oe_n_ff(p3e), .general_pin_four_in(pin4),
    .general_pin_four_out_ff(p4o), .general_pin_four_oe_n_ff(p4e),
    .general_pin_five_in(pin5), .general_pin_five_out_ff(p5o),
    .general_pin_five_oe_n_ff(p5e), .pec_error_ff(pec_err),
    .transfer_busy_ff(busy), .watchdog_fired_ff(wdt));
  bridge_slave_model i_bridge_slave_model (.sel(pin3), .sda(pin4), .scl(pin5),
    .nack_en(nack), .reply(reply), .pull_low(slv_pull));

  always #5 clk_sys = ~clk_sys;

  task automatic complete_run;
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run;
    end
  end

  function automatic logic [15:0] packet_error_code(input logic [47:0] d, input int n);
    logic [14:0] r;
    logic b;
    r = `PEC_SEED;
    for (int i = n - 1; i >= 0; i--) begin
      b = d[i] ^ r[14];
      r = {r[13:0], 1'b0} ^ (b ? `PEC_POLY : 15'h0);
    end
    return {r, 1'b0};
  endfunction

  function automatic logic [31:0] hdr(input logic [15:0] c);
    return {c, packet_error_code({32'h0, c}, 16)};
  endfunction

  // host frame in clock mode 3, one bit per 160 ns
  task automatic frame(input logic [103:0] bits, input int n);
    @(negedge clk_sys) cs_n = 0;
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      sck = 0;
      sdi = bits[103 - i];
      repeat (8) @(negedge clk_sys);
      sck = 1;
      repeat (8) @(negedge clk_sys);
    end
    cs_n = 1;
    repeat (12) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [47:0] d, input logic bad);
    frame({hdr(`CMD_BUF_WRITE), d, packet_error_code(d, 48) ^ {14'h0, bad, 1'b0}, 8'hff}, 96);
  endtask

  task automatic rd(input logic [47:0] e, input logic off);
    exp_q.push_back(off ? '1 : {e, packet_error_code(e, 48)});
    frame({hdr(`CMD_BUF_READ), {72{1'b1}}}, 96);
  endtask

  task automatic st;
    frame({hdr(`CMD_START_XFER), {72{1'b1}}}, 104);
  endtask

  // monitor collects each frame and judges read frames at chip-select rise
  always @(posedge sck) if (!cs_n) begin
    m_di = {m_di[94:0], sdi};
    m_do = {m_do[94:0], sdo_e | sdo_o};
    m_n++;
  end
  always @(negedge cs_n) m_n = 0;
  always @(posedge cs_n) if (m_n == 96 && m_di[95:80] === `CMD_BUF_READ)
    check("readback", exp_q.pop_front(), m_do[63:0]);

  initial begin
    logic [23:0] d;
    seed = $urandom(32'h5675c2d7);
    repeat (2) @(negedge clk_sys);
    sys_rst = 0;
    repeat (4) @(negedge clk_sys);
    rd('1, 0);
    reply = 24'($urandom);
    // select low first, held across slots
    wr({3{16'h8ff0}}, 0);
    st;
    repeat (100) @(negedge clk_sys);
    check("select_held", 0, p3e);
    for (int i = 0; i < 3000 && wdt !== 1'b1; i++) @(negedge clk_sys);
    check("watchdog", 4'hf, {wdt, p3e, p4e, p5e});
    rd({4'h7, reply[23:16], 8'hf7, reply[15:8], 8'hf7, reply[7:0], 4'hf}, 0);
    wr(48'h0123_4567_89ab, 1);
    check("pec_error", 1, pec_err);
    rd('1, 0);
    check("pec_error", 0, pec_err);
    for (int k = 0; k < 2; k++) begin
      d = 24'($urandom);
      nack = k[0];
      wr({4'h6, d[23:16], 8'h81, d[15:8], 8'h06, d[7:0], 4'h9}, 0);
      st;
      rd({4'h6, d[23:16], nack ? 8'hf1 : 8'h71, d[15:8], 8'hf6, d[7:0],
        nack ? 4'h9 : 4'h1}, 0);
    end
    d = 24'($urandom);
    // i2c no-transmit, then spi no-transmit and select high
    wr({4'h7, d[23:16], 8'h0f, d[15:8], 8'hf9, d[7:0], 4'h0}, 0);
    st;
    check("released", 3'h7, {p3e, p4e, p5e});
    rd({4'h7, d[23:16], 8'hf7, d[15:8], 8'hf7, d[7:0], 4'hf}, 0);
    strap = 1;
    repeat (8) @(negedge clk_sys);
    rd('1, 1);
    strap = 0;
    complete_run;
  end
endmodule
